// ### src/branch_increment_or_decode.sv
/*
  Execute stage for the absolute branch, increment-skip-zero and the two OR
  instructions. Assumes the fetch stage presents one instruction per cycle
  with its valid strobe, and the file register array returns the addressed
  byte combinationally from file_addr.
*/
`timescale 1ns/1ps
module branch_increment_or_decode (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Fetched instruction
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  input wire logic [7:0] program_page_latch,
  // File register port
  output logic [6:0] file_addr,
  input wire logic [7:0] file_rdata,
  output logic file_we_r,
  output logic [6:0] file_waddr_r,
  output logic [7:0] file_wdata_r,
  // Architectural state
  output logic [7:0] work_r,
  output logic zero_r,
  // Program counter load
  output logic pc_load_r,
  output logic [12:0] pc_target_r,
  // Prefetch discard
  output logic flush,
  output logic flush_pending_r
);
  alu_if alu ();
  logic exec;
  logic is_branch;
  logic is_inc_skip;
  logic is_or_lit;
  logic is_or_file;
  logic dest_file;

  alu_unit u_alu (
    .alu(alu.unit)
  );

  // A discarded slot still arrives as valid; it is simply not executed.
  assign exec = instr_valid && !flush_pending_r;
  assign is_branch = exec && (instr[branch_pkg::OP3_MSB:branch_pkg::OP3_LSB] ==
    branch_pkg::OP_BRANCH);
  assign is_inc_skip = exec && (instr[branch_pkg::OP6_MSB:branch_pkg::OP6_LSB] ==
    branch_pkg::OP_INC_SKIP);
  assign is_or_lit = exec && (instr[branch_pkg::OP6_MSB:branch_pkg::OP6_LSB] ==
    branch_pkg::OP_OR_LIT);
  assign is_or_file = exec && (instr[branch_pkg::OP6_MSB:branch_pkg::OP6_LSB] ==
    branch_pkg::OP_OR_FILE);
  assign dest_file = instr[branch_pkg::DEST_BIT];
  assign file_addr = instr[branch_pkg::FADDR_W-1:0];

  always_comb
  begin
    if (is_or_lit)
      alu.op = branch_pkg::ALU_OR_LIT;
    else if (is_or_file)
      alu.op = branch_pkg::ALU_OR_FILE;
    else
      alu.op = branch_pkg::ALU_INC;
  end
  assign alu.work = work_r;
  assign alu.file = file_rdata;
  assign alu.literal = instr[branch_pkg::DATA_W-1:0];

  assign flush = is_branch || (is_inc_skip && alu.zero);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      flush_pending_r <= 1'b0;
    else
      flush_pending_r <= flush;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pc_load_r <= 1'b0;
      pc_target_r <= branch_pkg::PC_RST;
    end
    else
    begin
      pc_load_r <= is_branch;
      if (is_branch)
        pc_target_r <= {program_page_latch[branch_pkg::PAGE_MSB:branch_pkg::PAGE_LSB],
          instr[branch_pkg::BR_LIT_W-1:0]};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      work_r <= branch_pkg::WORK_RST;
    else if (is_or_lit || ((is_inc_skip || is_or_file) && !dest_file))
      work_r <= alu.result;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      file_we_r <= 1'b0;
      file_waddr_r <= 7'h00;
      file_wdata_r <= 8'h00;
    end
    else
    begin
      file_we_r <= (is_inc_skip || is_or_file) && dest_file;
      if ((is_inc_skip || is_or_file) && dest_file)
      begin
        file_waddr_r <= file_addr;
        file_wdata_r <= alu.result;
      end
    end
  end

  // branch and skip leave flags alone
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      zero_r <= branch_pkg::ZERO_RST;
    else if (is_or_lit || is_or_file)
      zero_r <= alu.zero;
  end

  property p_branch_low;
    @(posedge ref_clk) disable iff (!rst_n)
    is_branch |=> pc_load_r && (pc_target_r[10:0] == $past(instr[10:0]));
  endproperty
  a_branch_low: assert property (p_branch_low) else $error("branch low pc wrong");

  property p_branch_page;
    @(posedge ref_clk) disable iff (!rst_n)
    is_branch |=> pc_target_r[12:11] == $past(program_page_latch[4:3]);
  endproperty
  a_branch_page: assert property (p_branch_page) else $error("branch page bits wrong");

  property p_branch_two_cycles;
    @(posedge ref_clk) disable iff (!rst_n)
    is_branch |=> flush_pending_r && !exec && $stable(zero_r) ##1 $stable(zero_r);
  endproperty
  a_branch_two_cycles: assert property (p_branch_two_cycles) else $error("branch slot");

  property p_inc_work;
    @(posedge ref_clk) disable iff (!rst_n)
    (is_inc_skip && !dest_file) |=> (work_r == $past(file_rdata) + 8'h01) && !file_we_r;
  endproperty
  a_inc_work: assert property (p_inc_work) else $error("increment to work wrong");

  property p_inc_skip;
    @(posedge ref_clk) disable iff (!rst_n)
    (is_inc_skip && file_rdata == 8'hff) |=> flush_pending_r && $stable(zero_r) && !exec;
  endproperty
  a_inc_skip: assert property (p_inc_skip) else $error("skip on zero missing");

  property p_or_lit;
    @(posedge ref_clk) disable iff (!rst_n)
    is_or_lit |=> (work_r == ($past(work_r) | $past(instr[7:0]))) && !flush_pending_r;
  endproperty
  a_or_lit: assert property (p_or_lit) else $error("or literal wrong");

  property p_or_file;
    @(posedge ref_clk) disable iff (!rst_n)
    (is_or_file && dest_file) |=> file_we_r && $stable(work_r) &&
      (file_wdata_r == ($past(work_r) | $past(file_rdata)));
  endproperty
  a_or_file: assert property (p_or_file) else $error("or file wrong");

  property p_zero_flag;
    @(posedge ref_clk) disable iff (!rst_n)
    (is_or_lit || (is_or_file && !dest_file)) |=> zero_r == (work_r == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  property p_or_file_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    (is_or_file && dest_file) |=> zero_r == (file_wdata_r == 8'h00);
  endproperty
  a_or_file_zero: assert property (p_or_file_zero) else $error("zero flag on file wrong");

  property p_inc_file;
    @(posedge ref_clk) disable iff (!rst_n)
    (is_inc_skip && dest_file) |=> file_we_r && $stable(work_r) &&
      (file_waddr_r == $past(file_addr)) && (file_wdata_r == $past(file_rdata) + 8'h01);
  endproperty
  a_inc_file: assert property (p_inc_file) else $error("increment to file wrong");

  // The flag must hold even when the incremented byte wraps to zero.
  property p_inc_flags;
    @(posedge ref_clk) disable iff (!rst_n)
    is_inc_skip |=> $stable(zero_r);
  endproperty
  a_inc_flags: assert property (p_inc_flags) else $error("increment changed zero flag");

  property p_no_skip;
    @(posedge ref_clk) disable iff (!rst_n)
    (is_inc_skip && file_rdata != 8'hff) |=> !flush_pending_r;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("skip without zero result");

  property p_discard;
    @(posedge ref_clk) disable iff (!rst_n)
    flush_pending_r |=> $stable(work_r) && $stable(zero_r) && !file_we_r && !pc_load_r;
  endproperty
  a_discard: assert property (p_discard) else $error("discarded slot took effect");

  property p_load_only_on_branch;
    @(posedge ref_clk) disable iff (!rst_n)
    !is_branch |=> !pc_load_r;
  endproperty
  a_load_only_on_branch: assert property (p_load_only_on_branch) else $error("stray pc load");
endmodule // branch_increment_or_decode

// ### src/branch_pkg.sv
/*
  Shared constants for the branch, increment-skip and OR execute block.
  Assumes a 14-bit instruction word and an 8-bit data path.
*/
package branch_pkg;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 13;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned BR_LIT_W = 11;
  // Opcode fields.
  localparam logic [2:0] OP_BRANCH = 3'h5;
  localparam logic [5:0] OP_INC_SKIP = 6'h0f;
  localparam logic [5:0] OP_OR_LIT = 6'h38;
  localparam logic [5:0] OP_OR_FILE = 6'h04;
  localparam int unsigned OP3_MSB = 13;
  localparam int unsigned OP3_LSB = 11;
  localparam int unsigned OP6_MSB = 13;
  localparam int unsigned OP6_LSB = 8;
  localparam int unsigned DEST_BIT = 7;
  // Page latch bits copied into the upper program counter.
  localparam int unsigned PAGE_MSB = 4;
  localparam int unsigned PAGE_LSB = 3;
  // Values after reset.
  localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
  localparam logic ZERO_RST = 1'b0;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  typedef enum logic [1:0] {ALU_INC, ALU_OR_LIT, ALU_OR_FILE} alu_op_e;
endpackage

// ### src/alu_if.sv
/*
  Carrier between the decoder and its arithmetic unit.
  Assumes both ends sit in the same clock domain.
*/
`timescale 1ns/1ps
interface alu_if;
  branch_pkg::alu_op_e op;
  logic [branch_pkg::DATA_W-1:0] work;
  logic [branch_pkg::DATA_W-1:0] file;
  logic [branch_pkg::DATA_W-1:0] literal;
  logic [branch_pkg::DATA_W-1:0] result;
  logic zero;
  modport decoder (output op, output work, output file, output literal, input result, input zero);
  modport unit (input op, input work, input file, input literal, output result, output zero);
endinterface // alu_if

// ### src/alu_unit.sv
/*
  Combinational increment and OR unit with zero detect.
  Assumes operands are stable within the executing cycle.
*/
`timescale 1ns/1ps
module alu_unit (
  // Operands and result
  alu_if.unit alu
);
  always_comb
  begin
    unique case (alu.op)
      branch_pkg::ALU_INC: alu.result = alu.file + 8'h01;
      branch_pkg::ALU_OR_LIT: alu.result = alu.work | alu.literal;
      branch_pkg::ALU_OR_FILE: alu.result = alu.work | alu.file;
      default: alu.result = 8'h00;
    endcase
  end

  assign alu.zero = (alu.result == 8'h00);
endmodule // alu_unit

// ### test/branch_increment_or_decode_tb.sv
/*
  Self-checking bench for the branch, increment-skip and OR execute block.
  Assumes the bench stands in for fetch and the file array, whose read data it drives.
*/
`timescale 1ns/1ps
module branch_increment_or_decode_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [13:0] instr = 14'h0000;
  logic [7:0] program_page_latch = 8'h00;
  logic [7:0] file_rdata = 8'h00;
  logic [6:0] file_addr;
  logic file_we_r;
  logic [6:0] file_waddr_r;
  logic [7:0] file_wdata_r;
  logic [7:0] work_r;
  logic zero_r;
  logic pc_load_r;
  logic [12:0] pc_target_r;
  logic flush;
  logic flush_pending_r;
  logic fl;
  logic [7:0] w = 8'h00;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;

  always #2 ref_clk = ~ref_clk;

  branch_increment_or_decode i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .program_page_latch(program_page_latch), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_we_r(file_we_r), .file_waddr_r(file_waddr_r),
    .file_wdata_r(file_wdata_r), .work_r(work_r), .zero_r(zero_r),
    .pc_load_r(pc_load_r), .pc_target_r(pc_target_r), .flush(flush),
    .flush_pending_r(flush_pending_r)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Present one word; flush is sampled once the edge has settled.
  task automatic issue(input logic [13:0] word, input logic [7:0] rd);
    @(posedge ref_clk);
    instr <= word;
    file_rdata <= rd;
    instr_valid <= 1'b1;
    #1 fl = flush;
  endtask

  task automatic idle();
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic test_or_lit(input logic [7:0] k);
    issue({branch_pkg::OP_OR_LIT, k}, 8'h00);
    w = w | k;
    idle();
    chk(work_r, w);
    chk(zero_r, w == 8'h00);
  endtask

  task automatic test_branch();
    @(posedge ref_clk);
    program_page_latch <= 8'h18;
    issue({branch_pkg::OP_BRANCH, 11'h5a5}, 8'h00);
    chk(fl, 1'b1);
    issue({branch_pkg::OP_OR_LIT, 8'hff}, 8'h00);
    chk(pc_load_r, 1'b1);
    chk(pc_target_r, 13'h1da5);
    chk(flush_pending_r, 1'b1);
    idle();
    chk(pc_load_r, 1'b0);
    chk(work_r, w);
    chk(zero_r, 1'b1);
  endtask

  task automatic test_inc_skip();
    issue({branch_pkg::OP_INC_SKIP, 1'b1, 7'h7f}, 8'hff);
    chk(file_addr, 7'h7f);
    chk(fl, 1'b1);
    issue({branch_pkg::OP_OR_LIT, 8'hff}, 8'h00);
    chk(fl, 1'b0);
    chk(file_we_r, 1'b1);
    chk(file_waddr_r, 7'h7f);
    chk(file_wdata_r, 8'h00);
    chk(flush_pending_r, 1'b1);
    chk(work_r, w);
    chk(zero_r, 1'b0);
    issue({branch_pkg::OP_INC_SKIP, 1'b0, 7'h00}, 8'h41);
    chk(work_r, w);
    chk(fl, 1'b0);
    w = 8'h42;
    idle();
    chk(work_r, w);
    chk(file_we_r, 1'b0);
    chk(flush_pending_r, 1'b0);
  endtask

  // OR with file to either destination.
  task automatic test_or_file();
    issue({branch_pkg::OP_OR_FILE, 1'b1, 7'h13}, 8'h91);
    idle();
    chk(file_we_r, 1'b1);
    chk(file_waddr_r, 7'h13);
    chk(file_wdata_r, 8'hd3);
    chk(work_r, w);
    issue({branch_pkg::OP_OR_FILE, 1'b0, 7'h05}, 8'h10);
    w = w | 8'h10;
    idle();
    chk(work_r, w);
    chk(zero_r, 1'b0);
    chk(file_we_r, 1'b0);
  endtask

  // skip with the wrapped result landing in work.
  task automatic test_skip_work();
    issue({branch_pkg::OP_INC_SKIP, 1'b0, 7'h2c}, 8'hff);
    chk(fl, 1'b1);
    w = 8'h00;
    idle();
    chk(work_r, w);
    chk(zero_r, 1'b0);
    chk(flush_pending_r, 1'b1);
    chk(file_we_r, 1'b0);
  endtask

  // A reset in mid-run must clear every registered output.
  task automatic test_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(work_r, branch_pkg::WORK_RST);
    chk(zero_r, branch_pkg::ZERO_RST);
    chk(pc_target_r, branch_pkg::PC_RST);
    chk(pc_load_r, 1'b0);
    chk(file_we_r, 1'b0);
    chk(file_wdata_r, 8'h00);
    chk(file_waddr_r, 7'h00);
    chk(flush_pending_r, 1'b0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    w = branch_pkg::WORK_RST;
  endtask

  task automatic results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // A hung run is cut short well past the few dozen cycles the tests need.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      results();
    end
  end

  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_or_lit(8'h00);
    test_branch();
    test_or_lit(8'h9a);
    test_or_lit(8'h35);
    test_inc_skip();
    test_or_file();
    test_skip_work();
    test_or_lit(8'h9a);
    test_reset();
    test_or_lit(8'h00);
    results();
  end
endmodule // branch_increment_or_decode_tb
